// >>> common/sps_pkg.sv
// ============
// shared pin function select: constants and types
// ============
package sps_pkg;

   // ============
   // register offsets (byte addresses)
   // ============
   localparam logic [7:0] SPS_OFS_GPIO_EN = 8'h00;
   localparam logic [7:0] SPS_OFS_GPIO_DIR = 8'h04;
   localparam logic [7:0] SPS_OFS_GPIO_OUT = 8'h08;
   localparam logic [7:0] SPS_OFS_GPIO_IN = 8'h0C;
   localparam logic [7:0] SPS_OFS_FUNC_SEL = 8'h10;
   localparam logic [7:0] SPS_OFS_CLK_STAT = 8'h14;

   // ============
   // function select fields and reset values
   // ============
   localparam int unsigned SPS_FS_PCI = 0;
   localparam int unsigned SPS_FS_ETHERNET_MAC_PORT = 1;
   localparam int unsigned SPS_FS_MDIO = 2;
   localparam int unsigned SPS_FS_SER0 = 3;
   localparam int unsigned SPS_FS_SER1 = 4;
   localparam int unsigned SPS_FS_W = 5;
   localparam logic [4:0] SPS_RST_FUNC_SEL = 5'h00;
   localparam logic [15:0] SPS_RST_GPIO_EN = 16'h0000;
   localparam logic [15:0] SPS_RST_GPIO_DIR = 16'h0000;
   localparam logic [15:0] SPS_RST_GPIO_OUT = 16'h0000;

   // clock status fields
   localparam int unsigned SPS_CS_RAW_LO = 0;
   localparam int unsigned SPS_CS_CODE_LO = 4;
   localparam int unsigned SPS_CS_FACT_LO = 8;
   localparam int unsigned SPS_CS_VALID = 16;

   // ============
   // general io bank layout
   // ============
   localparam int unsigned SPS_GPIO_W = 16;
   localparam int unsigned SPS_GP_QUARTER = 1;
   localparam int unsigned SPS_GP_SIXTH = 2;
   localparam int unsigned SPS_GP_INT_LO = 4;
   localparam int unsigned SPS_GP_INT_HI = 7;
   localparam int unsigned SPS_INT_W = 4;
   localparam logic [15:0] SPS_PCI_SHARED_MASK = 16'hFF00;

   // host data bus layout
   localparam int unsigned SPS_HD_W = 32;
   localparam int unsigned SPS_HD_SPLIT = 16;
   localparam int unsigned SPS_SER_W = 6;
   localparam int unsigned SPS_MD_W = 2;

   // ============
   // clock divider and strap timing counts
   // ============
   localparam int unsigned SPS_QUARTER_DIV = 4;
   localparam int unsigned SPS_SIXTH_DIV = 6;
   localparam logic [1:0] SPS_QUARTER_HALF = 2'(SPS_QUARTER_DIV / 2 - 1);
   localparam logic [1:0] SPS_SIXTH_HALF = 2'(SPS_SIXTH_DIV / 2 - 1);
   localparam logic [1:0] SPS_STRAP_SETTLE = 2'h2;

   // ============
   // types
   // ============
   typedef enum logic [1:0] {
      SPS_FN_NONE = 2'h0,
      SPS_FN_A = 2'h1,
      SPS_FN_B = 2'h2,
      SPS_FN_C = 2'h3
   } sps_fn_e;

   typedef enum logic [1:0] {
      SPS_MUL_X1 = 2'h0,
      SPS_MUL_X6 = 2'h1,
      SPS_MUL_X12 = 2'h2
   } sps_mult_e;

   localparam logic [7:0] SPS_FACT_X1 = 8'h01;
   localparam logic [7:0] SPS_FACT_X6 = 8'h06;
   localparam logic [7:0] SPS_FACT_X12 = 8'h0C;
   // pin code n picks the multiplier at bits [2n+1:2n]
   localparam logic [7:0] SPS_MULT_MAP = 8'h24;

   typedef struct packed {
      logic out;
      logic oe;
   } sps_drive_s;

endpackage

// >>> rtl/sps_pin_cell.sv
`timescale 1ns/10ps
`default_nettype none
// ============
// one shared pin: registered drive select, input synchroniser
// ============
module sps_pin_cell
   import sps_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // function select and candidate drives
   input wire sps_fn_e sel,
   input wire sps_drive_s src_a,
   input wire sps_drive_s src_b,
   input wire sps_drive_s src_c,
   // pad side
   input wire logic pad_in,
   output var sps_drive_s pad_drv_q,
   output logic pad_sync_q
);

   sps_drive_s drv_d;
   logic s1_q;

   // no function means released pad, neither driving nor driven
   always_comb begin
      unique case (sel)
         SPS_FN_A: drv_d = src_a;
         SPS_FN_B: drv_d = src_b;
         SPS_FN_C: drv_d = src_c;
         SPS_FN_NONE: drv_d = '0;
      endcase
   end

   // drive register and two-stage input synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_drv_q <= '0;
         s1_q <= 1'b0;
         pad_sync_q <= 1'b0;
      end else begin
         pad_drv_q <= drv_d;
         s1_q <= pad_in;
         pad_sync_q <= s1_q;
      end
   end

endmodule // sps_pin_cell
`default_nettype wire

// >>> rtl/sps_pin_function_select.sv
`timescale 1ns/10ps
`default_nettype none
module sps_pin_function_select
   import sps_pkg::*;
#(
   parameter int unsigned GPIO_W = SPS_GPIO_W,
   parameter int unsigned HD_W = SPS_HD_W,
   parameter int unsigned HD_SPLIT = SPS_HD_SPLIT,
   parameter int unsigned SER_W = SPS_SER_W,
   parameter logic [15:0] PCI_SHARED_MASK = SPS_PCI_SHARED_MASK,
   parameter logic [7:0] MULT_MAP = SPS_MULT_MAP
) (
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // general io bank pads
   input wire logic [GPIO_W-1:0] gp_pad_in,
   output logic [GPIO_W-1:0] gp_pad_out,
   output logic [GPIO_W-1:0] gp_pad_oe,
   // pci side of general io shared pins
   input wire logic [GPIO_W-1:0] pci_gp_out,
   input wire logic [GPIO_W-1:0] pci_gp_oe,
   output logic [GPIO_W-1:0] pci_gp_in,
   // external interrupt inputs toward the cpu
   output logic [SPS_INT_W-1:0] external_interrupt_input,
   // host data bus pads
   input wire logic [HD_W-1:0] hd_pad_in,
   output logic [HD_W-1:0] hd_pad_out,
   output logic [HD_W-1:0] hd_pad_oe,
   // host parallel port, pci and ethernet mac on the host data bus
   input wire logic [HD_W-1:0] hpp_out,
   input wire logic [HD_W-1:0] hpp_oe,
   output logic [HD_W-1:0] hpp_in,
   input wire logic [HD_W-1:0] pci_ad_out,
   input wire logic [HD_W-1:0] pci_ad_oe,
   output logic [HD_W-1:0] pci_ad_in,
   input wire logic [HD_W-HD_SPLIT-1:0] ethernet_mac_port_out,
   input wire logic [HD_W-HD_SPLIT-1:0] ethernet_mac_port_oe,
   output logic [HD_W-HD_SPLIT-1:0] ethernet_mac_port_in,
   // management clock/data pads and their two owners
   input wire logic [SPS_MD_W-1:0] md_pad_in,
   output logic [SPS_MD_W-1:0] md_pad_out,
   output logic [SPS_MD_W-1:0] md_pad_oe,
   input wire logic [SPS_MD_W-1:0] mdio_out,
   input wire logic [SPS_MD_W-1:0] mdio_oe,
   output logic [SPS_MD_W-1:0] mdio_in,
   input wire logic [SPS_MD_W-1:0] pci_md_out,
   input wire logic [SPS_MD_W-1:0] pci_md_oe,
   output logic [SPS_MD_W-1:0] pci_md_in,
   // serial port pads, port 0 in the low half, port 1 in the high half
   input wire logic [2*SER_W-1:0] sp_pad_in,
   output logic [2*SER_W-1:0] sp_pad_out,
   output logic [2*SER_W-1:0] sp_pad_oe,
   input wire logic [2*SER_W-1:0] bsp_out,
   input wire logic [2*SER_W-1:0] bsp_oe,
   output logic [2*SER_W-1:0] bsp_in,
   input wire logic [2*SER_W-1:0] vid_out,
   input wire logic [2*SER_W-1:0] vid_oe,
   output logic [2*SER_W-1:0] vid_in,
   // pll multiplier select pins and result
   input wire logic [1:0] pll_multiplier_select,
   output var sps_mult_e pll_mult_code,
   output logic [7:0] pll_mult_factor,
   output logic pll_mult_valid
);

   localparam int unsigned UP_W = HD_W - HD_SPLIT;

   // ============
   // register state
   // ============
   logic [GPIO_W-1:0] gp_en_q, gp_dir_q, gp_out_q;
   logic [SPS_FS_W-1:0] func_q;
   logic [1:0] quarter_cnt_q, sixth_cnt_q;
   logic quarter_clk_q, sixth_clk_q;
   logic [1:0] strap_s1_q, strap_s2_q, strap_raw_q, settle_q;

   // ============
   // apb decode
   // ============
   wire setup_ph = psel & ~penable;
   wire wr_en = psel & penable & pready & pwrite;
   wire hit_en = (paddr == SPS_OFS_GPIO_EN);
   wire hit_dir = (paddr == SPS_OFS_GPIO_DIR);
   wire hit_out = (paddr == SPS_OFS_GPIO_OUT);
   wire hit_in = (paddr == SPS_OFS_GPIO_IN);
   wire hit_fs = (paddr == SPS_OFS_FUNC_SEL);
   wire hit_cs = (paddr == SPS_OFS_CLK_STAT);
   wire hit_any = hit_en | hit_dir | hit_out | hit_in | hit_fs | hit_cs;

   // function select fields
   wire pci_on = func_q[SPS_FS_PCI];
   wire ethernet_mac_port_on = func_q[SPS_FS_ETHERNET_MAC_PORT];
   wire mdio_on = func_q[SPS_FS_MDIO];
   wire [1:0] ser_on = {func_q[SPS_FS_SER1], func_q[SPS_FS_SER0]};

   // synchronised pad levels from the pin cells
   logic [GPIO_W-1:0] gp_sync;
   logic [HD_W-1:0] hd_sync;
   logic [SPS_MD_W-1:0] md_sync;
   logic [2*SER_W-1:0] sp_sync;

   wire [31:0] clk_stat = {15'h0000, pll_mult_valid, pll_mult_factor,
                           2'h0, pll_mult_code, 2'h0, strap_raw_q};
   // read word chosen in setup, presented with pready in access
   wire [31:0] rd_word =
      hit_en ? 32'(gp_en_q) :
      hit_dir ? 32'(gp_dir_q) :
      hit_out ? 32'(gp_out_q) :
      hit_in ? 32'(gp_sync) :
      hit_fs ? 32'(func_q) :
      hit_cs ? clk_stat : 32'h0000_0000;

   // one wait-free access phase, error on unmapped offsets
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup_ph;
         pslverr <= setup_ph & ~hit_any;
         prdata <= setup_ph ? rd_word : 32'h0000_0000;
      end
   end

   // software registers; reset leaves every general io pin released except clock pins 1 and 2, which drive their divided clocks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gp_en_q <= SPS_RST_GPIO_EN[GPIO_W-1:0];
         gp_dir_q <= SPS_RST_GPIO_DIR[GPIO_W-1:0];
         gp_out_q <= SPS_RST_GPIO_OUT[GPIO_W-1:0];
         func_q <= SPS_RST_FUNC_SEL;
      end else if (wr_en) begin
         if (hit_en) gp_en_q <= pwdata[GPIO_W-1:0];
         if (hit_dir) gp_dir_q <= pwdata[GPIO_W-1:0];
         if (hit_out) gp_out_q <= pwdata[GPIO_W-1:0];
         if (hit_fs) func_q <= pwdata[SPS_FS_W-1:0];
      end
   end

   // ============
   // divided clock outputs
   // ============
   // quarter rate clock
   // sixth rate clock
   // both free-run so a pin handed back from general io keeps phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quarter_cnt_q <= 2'h0;
         sixth_cnt_q <= 2'h0;
         quarter_clk_q <= 1'b0;
         sixth_clk_q <= 1'b0;
      end else begin
         quarter_cnt_q <= (quarter_cnt_q == SPS_QUARTER_HALF) ? 2'h0 : quarter_cnt_q + 2'h1;
         sixth_cnt_q <= (sixth_cnt_q == SPS_SIXTH_HALF) ? 2'h0 : sixth_cnt_q + 2'h1;
         if (quarter_cnt_q == SPS_QUARTER_HALF) quarter_clk_q <= ~quarter_clk_q;
         if (sixth_cnt_q == SPS_SIXTH_HALF) sixth_clk_q <= ~sixth_clk_q;
      end
   end

   // ============
   // general io bank
   // ============
   sps_fn_e gp_sel [GPIO_W];
   for (genvar i = 0; i < GPIO_W; i++) begin : g_gp
      localparam bit IS_CLK = (i == SPS_GP_QUARTER) || (i == SPS_GP_SIXTH);
      localparam bit IS_PCI = PCI_SHARED_MASK[i];
      wire clk_bit = (i == SPS_GP_QUARTER) ? quarter_clk_q : sixth_clk_q;
      sps_drive_s pad_drv;
      // enable bit claims pin, direction bit drives
      // interrupt pins stay released until enabled
      // pci shared pins idle until the pci function is chosen
      assign gp_sel[i] = gp_en_q[i] ? SPS_FN_A :
                         IS_CLK ? SPS_FN_B :
                         (IS_PCI && pci_on) ? SPS_FN_C : SPS_FN_NONE;
      sps_pin_cell u_cell (
         .pclk(pclk),
         .presetn(presetn),
         .sel(gp_sel[i]),
         .src_a('{out: gp_out_q[i], oe: gp_dir_q[i]}),
         .src_b('{out: clk_bit, oe: 1'b1}),
         .src_c('{out: pci_gp_out[i], oe: pci_gp_oe[i]}),
         .pad_in(gp_pad_in[i]),
         .pad_drv_q(pad_drv),
         .pad_sync_q(gp_sync[i])
      );
      assign gp_pad_out[i] = pad_drv.out;
      assign gp_pad_oe[i] = pad_drv.oe;
   end

   // ============
   // host data bus: host port, pci, ethernet mac upper half
   // ============
   sps_fn_e hd_sel [HD_W];
   for (genvar i = 0; i < HD_W; i++) begin : g_hd
      localparam bit IS_UP = (i >= HD_SPLIT);
      localparam int unsigned UI = IS_UP ? i - HD_SPLIT : 0;
      sps_drive_s pad_drv;
      // ethernet mac may take the upper half
      assign hd_sel[i] = (IS_UP && ethernet_mac_port_on) ? SPS_FN_C :
                         pci_on ? SPS_FN_B : SPS_FN_A;
      sps_pin_cell u_cell (
         .pclk(pclk),
         .presetn(presetn),
         .sel(hd_sel[i]),
         .src_a('{out: hpp_out[i], oe: hpp_oe[i]}),
         .src_b('{out: pci_ad_out[i], oe: pci_ad_oe[i]}),
         .src_c('{out: ethernet_mac_port_out[UI], oe: ethernet_mac_port_oe[UI] & IS_UP}),
         .pad_in(hd_pad_in[i]),
         .pad_drv_q(pad_drv),
         .pad_sync_q(hd_sync[i])
      );
      assign hd_pad_out[i] = pad_drv.out;
      assign hd_pad_oe[i] = pad_drv.oe;
   end

   // ============
   // management pins shared with pci
   // ============
   for (genvar i = 0; i < SPS_MD_W; i++) begin : g_md
      sps_drive_s pad_drv;
      // pci pins here go to pci, never host
      // pci owns management pins by default
      wire sps_fn_e sel = mdio_on ? SPS_FN_A : SPS_FN_B;
      sps_pin_cell u_cell (
         .pclk(pclk),
         .presetn(presetn),
         .sel(sel),
         .src_a('{out: mdio_out[i], oe: mdio_oe[i]}),
         .src_b('{out: pci_md_out[i], oe: pci_md_oe[i]}),
         .src_c('0),
         .pad_in(md_pad_in[i]),
         .pad_drv_q(pad_drv),
         .pad_sync_q(md_sync[i])
      );
      assign md_pad_out[i] = pad_drv.out;
      assign md_pad_oe[i] = pad_drv.oe;
   end

   // ============
   // serial port pins shared with video ports
   // ============
   for (genvar i = 0; i < 2*SER_W; i++) begin : g_sp
      localparam int unsigned PORT = i / SER_W;
      sps_drive_s pad_drv;
      // video port unless serial port chosen
      wire sps_fn_e sel = ser_on[PORT] ? SPS_FN_A : SPS_FN_B;
      sps_pin_cell u_cell (
         .pclk(pclk),
         .presetn(presetn),
         .sel(sel),
         .src_a('{out: bsp_out[i], oe: bsp_oe[i]}),
         .src_b('{out: vid_out[i], oe: vid_oe[i]}),
         .src_c('0),
         .pad_in(sp_pad_in[i]),
         .pad_drv_q(pad_drv),
         .pad_sync_q(sp_sync[i])
      );
      assign sp_pad_out[i] = pad_drv.out;
      assign sp_pad_oe[i] = pad_drv.oe;
   end

   // ============
   // inputs returned only to the owning function
   // ============
   logic [GPIO_W-1:0] gp_pci_mask;
   logic [HD_W-1:0] hd_hpp_mask, hd_pci_mask;
   logic [UP_W-1:0] hd_ethernet_mac_port_mask;
   for (genvar i = 0; i < GPIO_W; i++) begin : g_gpm
      assign gp_pci_mask[i] = (gp_sel[i] == SPS_FN_C);
   end
   for (genvar i = 0; i < HD_W; i++) begin : g_hdm
      assign hd_hpp_mask[i] = (hd_sel[i] == SPS_FN_A);
      assign hd_pci_mask[i] = (hd_sel[i] == SPS_FN_B);
   end
   for (genvar i = 0; i < UP_W; i++) begin : g_emm
      assign hd_ethernet_mac_port_mask[i] = (hd_sel[i+HD_SPLIT] == SPS_FN_C);
   end
   // interrupt level follows pad while bit is an input
   wire [SPS_INT_W-1:0] int_lvl = gp_sync[SPS_GP_INT_HI:SPS_GP_INT_LO]
                                  & ~(gp_en_q[SPS_GP_INT_HI:SPS_GP_INT_LO]
                                      & gp_dir_q[SPS_GP_INT_HI:SPS_GP_INT_LO]);

   // masking stops an idle owner from seeing another function's traffic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pci_gp_in <= '0;
         external_interrupt_input <= '0;
         hpp_in <= '0;
         pci_ad_in <= '0;
         ethernet_mac_port_in <= '0;
         mdio_in <= '0;
         pci_md_in <= '0;
         bsp_in <= '0;
         vid_in <= '0;
      end else begin
         pci_gp_in <= gp_sync & gp_pci_mask;
         external_interrupt_input <= int_lvl;
         hpp_in <= hd_sync & hd_hpp_mask;
         pci_ad_in <= hd_sync & hd_pci_mask;
         ethernet_mac_port_in <= hd_sync[HD_W-1:HD_SPLIT] & hd_ethernet_mac_port_mask;
         mdio_in <= md_sync & {SPS_MD_W{mdio_on}};
         pci_md_in <= md_sync & {SPS_MD_W{~mdio_on}};
         bsp_in <= sp_sync & {{SER_W{ser_on[1]}}, {SER_W{ser_on[0]}}};
         vid_in <= sp_sync & ~{{SER_W{ser_on[1]}}, {SER_W{ser_on[0]}}};
      end
   end

   // ============
   // pll multiplier strap capture
   // ============
   wire sps_mult_e map_code = sps_mult_e'(MULT_MAP[2*strap_s2_q +: 2]);
   wire [7:0] map_fact = (map_code == SPS_MUL_X6) ? SPS_FACT_X6 :
                         (map_code == SPS_MUL_X12) ? SPS_FACT_X12 : SPS_FACT_X1;
   wire strap_take = ~pll_mult_valid && (settle_q == SPS_STRAP_SETTLE);

   // wait for synchroniser to fill, then latch once
   // decode pins into multiplier and factor
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_s1_q <= 2'h0;
         strap_s2_q <= 2'h0;
         settle_q <= 2'h0;
         strap_raw_q <= 2'h0;
         pll_mult_code <= SPS_MUL_X1;
         pll_mult_factor <= SPS_FACT_X1;
         pll_mult_valid <= 1'b0;
      end else begin
         strap_s1_q <= pll_multiplier_select;
         strap_s2_q <= strap_s1_q;
         if (settle_q != SPS_STRAP_SETTLE) settle_q <= settle_q + 2'h1;
         if (strap_take) begin
            strap_raw_q <= strap_s2_q;
            pll_mult_code <= map_code;
            pll_mult_factor <= map_fact;
            pll_mult_valid <= 1'b1;
         end
      end
   end

endmodule // sps_pin_function_select
`default_nettype wire

// >>> tb/sps_board.sv
`timescale 1ns/10ps
`default_nettype none
// ============
// board side of one group of shared pins
// ============
module sps_board #(
   parameter int W = 1,
   parameter bit PULL = 1'b1
) (
   // device pad side
   input wire logic [W-1:0] pad_out,
   input wire logic [W-1:0] pad_oe,
   // board driver, seen only where the device lets go
   input wire logic [W-1:0] ext_val,
   input wire logic [W-1:0] ext_en,
   output logic [W-1:0] pad_in
);
   // no pull: a released line flips so a stale level never passes
   wire logic [W-1:0] idle = PULL ? {W{1'b1}} : ~pad_out;
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en & idle);
endmodule // sps_board
`default_nettype wire

// >>> tb/sps_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ============
// pin mux checker
// ============
module sps_chk
   import sps_pkg::*;
#(
   parameter int unsigned GPIO_W = 16,
   parameter int unsigned HD_W = 32,
   parameter int unsigned SER_W = 6
) (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic pready,
   // pads and sources
   input wire logic [GPIO_W-1:0] gp_pad_out,
   input wire logic [GPIO_W-1:0] gp_pad_oe,
   input wire logic [HD_W-1:0] hd_pad_out,
   input wire logic [HD_W-1:0] hpp_out,
   input wire logic [SPS_MD_W-1:0] md_pad_out,
   input wire logic [SPS_MD_W-1:0] pci_md_out,
   input wire logic [2*SER_W-1:0] sp_pad_out,
   input wire logic [2*SER_W-1:0] vid_out,
   // multiplier
   input wire sps_mult_e pll_mult_code,
   input wire logic [7:0] pll_mult_factor,
   input wire logic pll_mult_valid
);
   // edges since reset; defaults hold only until software writes
   logic [3:0] up_q;
   logic en_wr_q;
   logic fs_wr_q;
   wire logic commit = psel && penable && pready && pwrite;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_q <= 4'h0;
         en_wr_q <= 1'b0;
         fs_wr_q <= 1'b0;
      end else begin
         up_q <= (up_q == 4'hF) ? up_q : up_q + 4'h1;
         en_wr_q <= en_wr_q | (commit && paddr <= SPS_OFS_GPIO_OUT);
         fs_wr_q <= fs_wr_q | (commit && paddr == SPS_OFS_FUNC_SEL);
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_one_access;
      pready ##1 !pready;
   endsequence
   AST_APB_ONE: assert property (s_setup |=> s_one_access)
      else $error("access phase not one cycle");
   AST_QUARTER: assert property (up_q > 4'h5 && !en_wr_q |->
      gp_pad_oe[1] && gp_pad_out[1] != $past(gp_pad_out[1], 2))
      else $error("quarter clock pin wrong");
   AST_SIXTH: assert property (up_q > 4'h7 && !en_wr_q |->
      gp_pad_oe[2] && gp_pad_out[2] != $past(gp_pad_out[2], 3))
      else $error("sixth clock pin wrong");
   AST_INT_PINS: assert property (!en_wr_q |-> gp_pad_oe[7:4] == 4'h0)
      else $error("interrupt pin drives");
   AST_PCI_GP: assert property (!en_wr_q && !fs_wr_q |-> gp_pad_oe[15:8] == 8'h00)
      else $error("pci shared gp pin drives");
   AST_HOST: assert property (up_q > 4'h1 && !fs_wr_q |-> hd_pad_out == $past(hpp_out))
      else $error("host data pads not host port");
   AST_MD: assert property (up_q > 4'h1 && !fs_wr_q |-> md_pad_out == $past(pci_md_out))
      else $error("management pads not pci");
   AST_SP: assert property (up_q > 4'h1 && !fs_wr_q |-> sp_pad_out == $past(vid_out))
      else $error("serial pads not video");
   AST_MUL_TIME: assert property ($rose(pll_mult_valid) |-> up_q == 4'h3)
      else $error("multiplier captured at wrong edge");
   AST_MUL_FACT: assert property (pll_mult_valid |-> pll_mult_factor ==
      (pll_mult_code == SPS_MUL_X6 ? 8'h06 : pll_mult_code == SPS_MUL_X12 ? 8'h0C : 8'h01))
      else $error("multiplier factor wrong");
   AST_MUL_HOLD: assert property (pll_mult_valid |=> $stable(pll_mult_code))
      else $error("multiplier code changed");
endmodule // sps_chk
bind sps_pin_function_select sps_chk #(.GPIO_W(GPIO_W), .HD_W(HD_W), .SER_W(SER_W)) u_chk (.*);
`default_nettype wire

// >>> tb/shared_pin_function_select_bench.sv
`timescale 1ns/10ps
`default_nettype none
module shared_pin_function_select_bench;
   import sps_pkg::*;
   // ============
   // signals, sources hold distinct patterns
   // ============
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pll_mult_valid, err;
   logic [7:0] paddr, pll_mult_factor;
   logic [31:0] pwdata, prdata, rd, hd_pad_in, hd_pad_out, hd_pad_oe, hpp_in, pci_ad_in;
   logic [31:0] hpp_out = 32'hA5A55A5A, pci_ad_out = 32'h12345678, oe = 32'hFFFFFFFF;
   logic [15:0] gp_pad_in, gp_pad_out, gp_pad_oe, pci_gp_in, ethernet_mac_port_in, gp_ext;
   logic [15:0] pci_gp_out = 16'hAA00, pci_gp_oe = 16'hFF00, ethernet_mac_port_out = 16'hC3C3;
   logic [11:0] sp_pad_in, sp_pad_out, sp_pad_oe, bsp_in, vid_in;
   logic [11:0] bsp_out = 12'hABC, vid_out = 12'h535;
   logic [3:0] external_interrupt_input;
   logic [1:0] md_pad_in, md_pad_out, md_pad_oe, mdio_in, pci_md_in, pll_multiplier_select;
   logic [1:0] mdio_out = 2'h1, pci_md_out = 2'h2;
   sps_mult_e pll_mult_code;
   int n_mismatch, compares, cycles;
   sps_pin_function_select uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .gp_pad_in, .gp_pad_out, .gp_pad_oe, .pci_gp_out,
      .pci_gp_oe, .pci_gp_in, .external_interrupt_input, .hd_pad_in, .hd_pad_out, .hd_pad_oe,
      .hpp_out, .hpp_oe(oe), .hpp_in, .pci_ad_out, .pci_ad_oe(oe), .pci_ad_in,
      .ethernet_mac_port_out, .ethernet_mac_port_oe(oe[15:0]), .ethernet_mac_port_in, .md_pad_in, .md_pad_out, .md_pad_oe,
      .mdio_out, .mdio_oe(oe[1:0]), .mdio_in, .pci_md_out, .pci_md_oe(oe[1:0]),
      .pci_md_in, .sp_pad_in, .sp_pad_out, .sp_pad_oe, .bsp_out, .bsp_oe(oe[11:0]),
      .bsp_in, .vid_out, .vid_oe(oe[11:0]), .vid_in, .pll_multiplier_select,
      .pll_mult_code, .pll_mult_factor, .pll_mult_valid);
   // board: general io has pull-ups, other pads only loop back
   sps_board #(.W(16)) u_gp (.pad_out(gp_pad_out), .pad_oe(gp_pad_oe), .ext_val(gp_ext),
      .ext_en(16'h00F0), .pad_in(gp_pad_in));
   sps_board #(.W(46), .PULL(1'b0)) u_lb (.pad_out({sp_pad_out, md_pad_out, hd_pad_out}),
      .pad_oe({sp_pad_oe, md_pad_oe, hd_pad_oe}), .ext_val(46'h0), .ext_en(46'h0),
      .pad_in({sp_pad_in, md_pad_in, hd_pad_in}));
   // ============
   // clock, watchdog, shared tasks
   // ============
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // a hang counts as a mismatch and closes the run
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   task automatic wrap_up;
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // apb master: no fixed latency assumed, waits for pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // ============
   // scenarios
   // ============
   task automatic t_strap(input logic [1:0] strap);
      logic [1:0] code;
      presetn <= 1'b0;
      pll_multiplier_select <= strap;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      code = SPS_MULT_MAP[2*strap +: 2];
      check({30'h0, pll_mult_code}, {30'h0, code});
      check({24'h0, pll_mult_factor}, code == 2'h1 ? 6 : code == 2'h2 ? 12 : 1);
      pll_multiplier_select <= ~strap;
      repeat (6) @(posedge pclk);
      check({30'h0, pll_mult_code}, {30'h0, code});
   endtask
   task automatic t_defaults;
      int q;
      int s;
      logic [1:0] last;
      check({16'h0, gp_pad_oe}, 32'h00000006);
      check(hd_pad_out, hpp_out);
      check(hpp_in, hpp_out);
      check({30'h0, md_pad_out}, {30'h0, pci_md_out});
      check({20'h0, sp_pad_out}, {20'h0, vid_out});
      check({16'h0, pci_gp_in}, 32'h0);
      q = 0;
      s = 0;
      last = gp_pad_out[2:1];
      repeat (24) begin
         @(posedge pclk);
         q = q + int'(gp_pad_out[1] !== last[0]);
         s = s + int'(gp_pad_out[2] !== last[1]);
         last = gp_pad_out[2:1];
      end
      check(q, 24 / (SPS_QUARTER_DIV / 2));
      check(s, 24 / (SPS_SIXTH_DIV / 2));
   endtask
   task automatic t_gpio;
      gp_ext <= 16'h00A0;
      apb(1'b1, SPS_OFS_GPIO_EN, 32'h000000F2);
      apb(1'b1, SPS_OFS_GPIO_DIR, 32'h00000002);
      apb(1'b1, SPS_OFS_GPIO_OUT, 32'h00000002);
      repeat (4) @(posedge pclk);
      check({16'h0, gp_pad_oe}, 32'h00000006);
      check({31'h0, gp_pad_out[1]}, 32'h1);
      check({28'h0, external_interrupt_input}, 32'hA);
      apb(1'b0, SPS_OFS_GPIO_IN, 32'h0);
      check(rd & 32'h000000F3, 32'h000000A3);
      apb(1'b1, SPS_OFS_GPIO_DIR, 32'h0);
      repeat (2) @(posedge pclk);
      check({16'h0, gp_pad_oe}, 32'h00000004);
      apb(1'b1, SPS_OFS_GPIO_EN, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      check({31'h0, err}, 32'h1);
      check({16'h0, gp_pad_oe}, 32'h00000006);
   endtask
   task automatic t_func;
      apb(1'b1, SPS_OFS_FUNC_SEL, 32'h0000001F);
      repeat (2) @(posedge pclk);
      check(hd_pad_out, {ethernet_mac_port_out, pci_ad_out[15:0]});
      check({30'h0, md_pad_out}, {30'h0, mdio_out});
      check({20'h0, sp_pad_out}, {20'h0, bsp_out});
      check({16'h0, gp_pad_oe}, {16'h0, pci_gp_oe | 16'h0006});
      repeat (2) @(posedge pclk);
      check({16'h0, ethernet_mac_port_in}, {16'h0, ethernet_mac_port_out});
      check(hpp_in, 32'h0);
      apb(1'b1, SPS_OFS_FUNC_SEL, 32'h0);
      repeat (2) @(posedge pclk);
      check(hd_pad_out, hpp_out);
      oe <= 32'h0;
      repeat (2) @(posedge pclk);
      check(hd_pad_oe, 32'h0);
   endtask
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      gp_ext = 16'h0050;
      pll_multiplier_select = 2'h0;
      @(posedge pclk);
      for (int m = 0; m < 3; m++) t_strap(2'(m));
      t_defaults();
      t_gpio();
      t_func();
      wrap_up();
   end
endmodule // shared_pin_function_select_bench
`default_nettype wire
